//--- core/csec_status_bank.sv
// Channel status, lane status and clear-on-read error counter register bank
`timescale 1ns/1ps
`include "csec_regs.svh"

module csec_status_bank #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic datapath_reset,
  // Management access
  input wire csec_pkg::csec_mgmt_req_t mgmt_req,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  // Datapath status
  input wire csec_pkg::csec_hs_stat_t hs_stat,
  input wire csec_pkg::csec_ls_stat_t ls_stat,
  input wire csec_pkg::csec_verify_t verify,
  // Device pin
  input wire logic pseudo_random_check_pin,
  // Lane select field out to the lane muxes
  output logic [1:0] slow_status_lane_select
);
  import csec_pkg::*;

  if (CNT_W != 16) begin : g_bad_width
    $error("csec_status_bank: counter width must be 16");
  end

  // ------------------------------------------------------------
  // Pin synchroniser
  // ------------------------------------------------------------
  logic prbs_s1_q;
  logic prbs_s2_q;
  logic prbs_s3_q;
  logic prbs_q;
  logic prbs_d;

  // A change is taken only once the last two stages agree
  assign prbs_d = (prbs_s2_q == prbs_s3_q) ? prbs_s3_q : prbs_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prbs_s1_q <= 1'b0;
      prbs_s2_q <= 1'b0;
      prbs_s3_q <= 1'b0;
      prbs_q <= 1'b0;
    end else begin
      prbs_s1_q <= pseudo_random_check_pin;
      prbs_s2_q <= prbs_s1_q;
      prbs_s3_q <= prbs_s2_q;
      prbs_q <= prbs_d;
    end
  end

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  wire rd_cs = mgmt_req.rd_stb && (mgmt_req.addr == `CSEC_OFS_CHAN_STATUS);
  wire rd_hs = mgmt_req.rd_stb && (mgmt_req.addr == `CSEC_OFS_HS_ERR);
  wire rd_ls0 = mgmt_req.rd_stb && (mgmt_req.addr == `CSEC_OFS_LS0_ERR);
  wire rd_lss = mgmt_req.rd_stb && (mgmt_req.addr == `CSEC_OFS_LS_STATUS);
  wire wr_cfg = mgmt_req.wr_stb && (mgmt_req.addr == `CSEC_OFS_LANE_CFG);
  wire wr_ra = mgmt_req.wr_stb && (mgmt_req.addr == `CSEC_OFS_RSVD_A);
  wire wr_rb = mgmt_req.wr_stb && (mgmt_req.addr == `CSEC_OFS_RSVD_B);

  // ------------------------------------------------------------
  // Lane select and reserved storage
  // ------------------------------------------------------------
  logic [1:0] lane_sel_q;
  logic [15:0] rsvd_a_q;
  logic [15:0] rsvd_b_q;

  wire lane0_sel = (lane_sel_q == `CSEC_LANE0);
  assign slow_status_lane_select = lane_sel_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lane_sel_q <= `CSEC_LANE0;
      rsvd_a_q <= `CSEC_ZERO16;
      rsvd_b_q <= `CSEC_ZERO16;
    end else begin
      if (wr_cfg) begin
        lane_sel_q <= mgmt_req.wdata[`CSEC_LANE_SEL_HI:`CSEC_LANE_SEL_LO];
      end
      if (wr_ra) begin
        rsvd_a_q <= mgmt_req.wdata & `CSEC_RSVD_A_MASK;
      end
      if (wr_rb) begin
        rsvd_b_q <= mgmt_req.wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // Latched status bits
  // ------------------------------------------------------------
  logic [`CSEC_NLAT-1:0] live;
  logic [`CSEC_NLAT-1:0] lat_clr;
  logic [`CSEC_NLAT-1:0] lat_view;
  localparam logic [`CSEC_NLAT-1:0] LAT_LOW = `CSEC_LAT_LOW_MASK;

  assign live[`CSEC_L_FAST_SIDE_SIGNAL_LOST] = hs_stat.signal_lost;
  assign live[`CSEC_L_AZ] = hs_stat.autozero_done;
  assign live[`CSEC_L_BAD_CW] = hs_stat.bad_codeword;
  assign live[`CSEC_L_TX_OVF] = hs_stat.tx_fifo_ovf;
  assign live[`CSEC_L_RX_OVF] = hs_stat.rx_fifo_ovf;
  assign live[`CSEC_L_SLOW_SIDE_SIGNAL_LOST] = ls_stat.signal_lost;
  assign live[`CSEC_L_LS_SYNC] = ls_stat.sync;
  assign live[`CSEC_L_LS_BAD] = ls_stat.bad_codeword;

  // Lane bits are only released by a read that actually shows lane 0
  assign lat_clr = {{3{rd_lss && lane0_sel}}, {5{rd_cs}}};

  for (genvar i = 0; i < `CSEC_NLAT; i++) begin : g_lat
    csec_latch_bit #(
      .LATCH_LOW(LAT_LOW[i])
    ) u_csec_latch_bit (
      .clk(clk),
      .rst(rst),
      .datapath_reset(datapath_reset),
      .live(live[i]),
      .clr(lat_clr[i]),
      .view(lat_view[i])
    );
  end

  // ------------------------------------------------------------
  // Error counter sources
  // ------------------------------------------------------------
  // countable fast and slow patterns
  wire hs_pat_ok = verify.hs_pattern >= `CSEC_PAT_FIRST_COUNTED;
  wire hs_prbs_ok = verify.hs_pattern >= `CSEC_PAT_FIRST_PRBS;
  wire ls_pat_ok = verify.ls_pattern >= `CSEC_PAT_FIRST_COUNTED;

  wire hs_pin_inc = prbs_q && hs_prbs_ok && hs_stat.pattern_err;
  wire hs_ver_inc = !prbs_q && verify.hs_verify_en && hs_pat_ok && hs_stat.pattern_err;
  wire hs_fun_inc = !prbs_q && !verify.hs_verify_en && hs_stat.bad_codeword;
  wire hs_inc = hs_pin_inc || hs_ver_inc || hs_fun_inc;

  wire ls_inc = verify.ls_verify_en ? (ls_pat_ok && ls_stat.pattern_err)
                                    : ls_stat.bad_codeword;

  // ------------------------------------------------------------
  // Error counters
  // ------------------------------------------------------------
  logic [CNT_W-1:0] hs_cnt_q;
  logic [CNT_W-1:0] ls_cnt_q;

  csec_err_counter #(
    .CNT_W(CNT_W)
  ) u_csec_err_counter_hs (
    .clk(clk),
    .rst(rst),
    .datapath_reset(datapath_reset),
    .inc(hs_inc),
    .rd_clr(rd_hs),
    .count(hs_cnt_q)
  );

  csec_err_counter #(
    .CNT_W(CNT_W)
  ) u_csec_err_counter_ls (
    .clk(clk),
    .rst(rst),
    .datapath_reset(datapath_reset),
    .inc(ls_inc),
    .rd_clr(rd_ls0),
    .count(ls_cnt_q)
  );

  // ------------------------------------------------------------
  // Status words
  // ------------------------------------------------------------
  logic [15:0] chan_word;
  logic [15:0] lane_word;

  always_comb begin
    chan_word = `CSEC_ZERO16;
    chan_word[`CSEC_CS_HS_PAT] = hs_stat.pat_aligned;
    chan_word[`CSEC_CS_LS_PAT] = ls_stat.pat_aligned;
    chan_word[`CSEC_CS_FAST_SIDE_SIGNAL_LOST] = lat_view[`CSEC_L_FAST_SIDE_SIGNAL_LOST];
    chan_word[`CSEC_CS_AZ_DONE] = lat_view[`CSEC_L_AZ];
    chan_word[`CSEC_CS_AGC] = hs_stat.gain_locked;
    chan_word[`CSEC_CS_SYNC] = hs_stat.sync;
    chan_word[`CSEC_CS_BAD_CW] = lat_view[`CSEC_L_BAD_CW];
    chan_word[`CSEC_CS_TX_OVF] = lat_view[`CSEC_L_TX_OVF];
    chan_word[`CSEC_CS_RX_OVF] = lat_view[`CSEC_L_RX_OVF];
    chan_word[`CSEC_CS_LS_PLL] = hs_stat.slow_pll_locked;
    chan_word[`CSEC_CS_HS_PLL] = hs_stat.fast_pll_locked;
  end

  always_comb begin
    lane_word = `CSEC_ZERO16;
    if (lane0_sel) begin
      lane_word[`CSEC_SLOW_SIDE_SIGNAL_LOST] = lat_view[`CSEC_L_SLOW_SIDE_SIGNAL_LOST];
      lane_word[`CSEC_LS_SYNC] = lat_view[`CSEC_L_LS_SYNC];
      lane_word[`CSEC_LS_BAD_CW] = lat_view[`CSEC_L_LS_BAD];
    end
  end

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  logic [15:0] rd_mux;
  logic [15:0] rdata_q;
  logic rvalid_q;

  always_comb begin
    unique case (mgmt_req.addr)
      `CSEC_OFS_LANE_CFG: rd_mux = {2'h0, lane_sel_q, 12'h000};
      `CSEC_OFS_CHAN_STATUS: rd_mux = chan_word;
      `CSEC_OFS_HS_ERR: rd_mux = hs_cnt_q;
      `CSEC_OFS_LS0_ERR: rd_mux = ls_cnt_q;
      `CSEC_OFS_LS_STATUS: rd_mux = lane_word;
      `CSEC_OFS_RSVD_A: rd_mux = rsvd_a_q;
      `CSEC_OFS_RSVD_B: rd_mux = rsvd_b_q;
      default: rd_mux = `CSEC_ZERO16;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= `CSEC_ZERO16;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= mgmt_req.rd_stb;
      if (mgmt_req.rd_stb) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign mgmt_rdata = rdata_q;
  assign mgmt_rvalid = rvalid_q;

endmodule : csec_status_bank

// ------------------------------------------------------------
// One latched status bit
// ------------------------------------------------------------
module csec_latch_bit #(
  parameter bit LATCH_LOW = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic datapath_reset,
  // Live condition and read release
  input wire logic live,
  input wire logic clr,
  // Value shown to a read
  output logic view
);
  import csec_pkg::*;

  logic lat_q;

  // Event: condition high for latch-high slots, low for latch-low slots
  wire ev = LATCH_LOW ? !live : live;
  // Set wins over a release in the same cycle
  wire lat_d = ev || (lat_q && !clr);
  assign view = LATCH_LOW ? (live && !lat_q) : (live || lat_q);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lat_q <= 1'b0;
    end else if (datapath_reset) begin
      lat_q <= 1'b0;
    end else begin
      lat_q <= lat_d;
    end
  end

endmodule : csec_latch_bit

// ------------------------------------------------------------
// Clear-on-read saturating error counter
// ------------------------------------------------------------
module csec_err_counter #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic datapath_reset,
  // Control
  input wire logic inc,
  input wire logic rd_clr,
  // Count
  output logic [CNT_W-1:0] count
);
  import csec_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  if (CNT_W != 16) begin : g_bad_width
    $error("csec_err_counter: counter width must be 16");
  end

  // Sticks at full scale rather than wrap to a small, misleading value
  wire full = (cnt_q == `CSEC_ERR_MAX);

  // A same-cycle error survives the clear
  assign cnt_d = rd_clr ? (inc ? `CSEC_ERR_ONE : `CSEC_ZERO16)
               : ((inc && !full) ? cnt_q + `CSEC_ERR_ONE : cnt_q);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= `CSEC_ERR_RESET;
    end else if (datapath_reset) begin
      cnt_q <= `CSEC_ERR_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign count = cnt_q;

endmodule : csec_err_counter

//--- core/csec_regs.svh
// Register offsets, field positions and reset values of the channel status group
`ifndef CSEC_REGS_SVH
`define CSEC_REGS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define CSEC_ADDR_W 16
`define CSEC_OFS_LANE_CFG 16'h000c
`define CSEC_OFS_CHAN_STATUS 16'h000f
`define CSEC_OFS_HS_ERR 16'h0010
`define CSEC_OFS_LS0_ERR 16'h0011
`define CSEC_OFS_LS_STATUS 16'h0015
`define CSEC_OFS_RSVD_A 16'h0016
`define CSEC_OFS_RSVD_B 16'h0017
`define CSEC_OFS_RSVD_STAT 16'h0023

// ------------------------------------------------------------
// Reset values and masks
// ------------------------------------------------------------
`define CSEC_ERR_RESET 16'hfffd
`define CSEC_ERR_MAX 16'hffff
`define CSEC_ERR_ONE 16'h0001
`define CSEC_ZERO16 16'h0000
`define CSEC_RSVD_A_MASK 16'h0f7f
`define CSEC_LANE0 2'h0

// ------------------------------------------------------------
// Channel status bit positions
// ------------------------------------------------------------
`define CSEC_CS_HS_PAT 15
`define CSEC_CS_LS_PAT 14
`define CSEC_CS_FAST_SIDE_SIGNAL_LOST 13
`define CSEC_CS_AZ_DONE 12
`define CSEC_CS_AGC 11
`define CSEC_CS_SYNC 10
`define CSEC_CS_BAD_CW 8
`define CSEC_CS_TX_OVF 6
`define CSEC_CS_RX_OVF 4
`define CSEC_CS_LS_PLL 1
`define CSEC_CS_HS_PLL 0

// ------------------------------------------------------------
// Low-speed status and lane-select positions
// ------------------------------------------------------------
`define CSEC_SLOW_SIDE_SIGNAL_LOST 10
`define CSEC_LS_SYNC 8
`define CSEC_LS_BAD_CW 3
`define CSEC_LANE_SEL_HI 13
`define CSEC_LANE_SEL_LO 12

// ------------------------------------------------------------
// Latched bit slots
// ------------------------------------------------------------
`define CSEC_NLAT 8
`define CSEC_L_FAST_SIDE_SIGNAL_LOST 0
`define CSEC_L_AZ 1
`define CSEC_L_BAD_CW 2
`define CSEC_L_TX_OVF 3
`define CSEC_L_RX_OVF 4
`define CSEC_L_SLOW_SIDE_SIGNAL_LOST 5
`define CSEC_L_LS_SYNC 6
`define CSEC_L_LS_BAD 7
// Slots that latch low rather than high
`define CSEC_LAT_LOW_MASK 8'h42

// ------------------------------------------------------------
// Pattern codes that carry an error count
// ------------------------------------------------------------
`define CSEC_PAT_FIRST_COUNTED 3'h3
`define CSEC_PAT_FIRST_PRBS 3'h5

`endif

//--- core/csec_pkg.sv
// Types shared by the channel status and error counter block
package csec_pkg;

  // High-speed side live status and events
  typedef struct packed {
    logic pat_aligned;
    logic signal_lost;
    logic autozero_done;
    logic gain_locked;
    logic sync;
    logic bad_codeword;
    logic pattern_err;
    logic tx_fifo_ovf;
    logic rx_fifo_ovf;
    logic slow_pll_locked;
    logic fast_pll_locked;
  } csec_hs_stat_t;

  // Low-speed lane 0 live status and events
  typedef struct packed {
    logic pat_aligned;
    logic signal_lost;
    logic sync;
    logic bad_codeword;
    logic pattern_err;
  } csec_ls_stat_t;

  // Pattern verification setup
  typedef struct packed {
    logic hs_verify_en;
    logic [2:0] hs_pattern;
    logic ls_verify_en;
    logic [2:0] ls_pattern;
  } csec_verify_t;

  // Management register access
  typedef struct packed {
    logic rd_stb;
    logic wr_stb;
    logic [15:0] addr;
    logic [15:0] wdata;
  } csec_mgmt_req_t;

endpackage : csec_pkg

//--- test/csec_status_bank_asserts.sv
// Concurrent checks for the channel status and error counter bank
`timescale 1ns/1ps
`include "csec_regs.svh"

module csec_status_bank_asserts #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic datapath_reset,
  // Management access
  input wire csec_pkg::csec_mgmt_req_t mgmt_req,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid,
  // Datapath status
  input wire csec_pkg::csec_hs_stat_t hs_stat,
  input wire csec_pkg::csec_ls_stat_t ls_stat,
  input wire csec_pkg::csec_verify_t verify,
  input wire logic pseudo_random_check_pin,
  input wire logic [1:0] slow_status_lane_select
);
  import csec_pkg::*;
  // ----
  // Decodes
  // ----
  wire rd_cs = mgmt_req.rd_stb && mgmt_req.addr == `CSEC_OFS_CHAN_STATUS;
  wire rd_hs = mgmt_req.rd_stb && mgmt_req.addr == `CSEC_OFS_HS_ERR;
  wire rd_l0 = mgmt_req.rd_stb && mgmt_req.addr == `CSEC_OFS_LS0_ERR;
  wire rd_ls = mgmt_req.rd_stb && mgmt_req.addr == `CSEC_OFS_LS_STATUS;
  wire lane0 = slow_status_lane_select == `CSEC_LANE0;
  wire dpr = datapath_reset;
  // Anything that could move a counter, reload included
  wire hs_ev = hs_stat.bad_codeword || hs_stat.pattern_err || dpr;
  wire ls_ev = ls_stat.bad_codeword || ls_stat.pattern_err || dpr;
  wire [5:0] live6 = {hs_stat.pat_aligned, ls_stat.pat_aligned, hs_stat.gain_locked,
    hs_stat.sync, hs_stat.slow_pll_locked, hs_stat.fast_pll_locked};

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_sticky(ev, rd, int b);
    (ev && !rd && !dpr) ##1 (rd && !dpr) |=> mgmt_rdata[b];
  endproperty

  rvalid_after_read_a: assert property (mgmt_req.rd_stb |=> mgmt_rvalid)
    else $error("read strobe not answered");
  hs_clear_a: assert property ((rd_hs && !hs_ev) ##1 !hs_ev ##1 rd_hs
    |=> mgmt_rdata == `CSEC_ZERO16) else $error("fast counter not cleared by read");
  ls0_clear_a: assert property ((rd_l0 && !ls_ev) ##1 !ls_ev ##1 rd_l0
    |=> mgmt_rdata == `CSEC_ZERO16) else $error("lane counter not cleared by read");
  live_bits_a: assert property (rd_cs |=> mgmt_rdata[15:14] == $past(live6[5:4]) &&
    mgmt_rdata[11:10] == $past(live6[3:2]) && mgmt_rdata[1:0] == $past(live6[1:0]))
    else $error("live status bits wrong");
  fast_side_signal_lost_latch_a: assert property (p_sticky(hs_stat.signal_lost, rd_cs, 13))
    else $error("fast signal loss not held");
  az_low_a: assert property ((!hs_stat.autozero_done && !rd_cs && !dpr) ##1
    (rd_cs && !dpr) |=> !mgmt_rdata[12]) else $error("autozero drop not held");
  bad_cw_latch_a: assert property (p_sticky(hs_stat.bad_codeword, rd_cs, 8))
    else $error("fast bad codeword not held");
  tx_ovf_latch_a: assert property (p_sticky(hs_stat.tx_fifo_ovf, rd_cs, 6))
    else $error("transmit overflow not held");
  rx_ovf_latch_a: assert property (p_sticky(hs_stat.rx_fifo_ovf, rd_cs, 4))
    else $error("receive overflow not held");
  slow_side_signal_lost_latch_a: assert property (p_sticky(ls_stat.signal_lost, rd_ls && lane0, 10))
    else $error("slow signal loss not held");
  ls_sync_low_a: assert property ((!ls_stat.sync && !rd_ls && !dpr) ##1
    (rd_ls && lane0 && !dpr) |=> !mgmt_rdata[8]) else $error("slow sync drop not held");
  lane_other_a: assert property (rd_ls && !lane0 |=>
    {mgmt_rdata[10], mgmt_rdata[8], mgmt_rdata[3]} == 3'h0) else $error("other lane shown");
  release_a: assert property ((rd_cs && !hs_stat.signal_lost) ##1 !hs_stat.signal_lost ##1
    (rd_cs && !hs_stat.signal_lost) |=> !mgmt_rdata[13]) else $error("latch not released");

  cover property (rd_hs ##2 rd_hs);
  cover property (hs_stat.tx_fifo_ovf ##1 rd_cs);
  cover property (rd_ls && !lane0);
endmodule : csec_status_bank_asserts

bind csec_status_bank csec_status_bank_asserts #(.CNT_W(CNT_W)) u_csec_status_bank_asserts (
  .clk(clk), .rst(rst), .datapath_reset(datapath_reset), .mgmt_req(mgmt_req),
  .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .hs_stat(hs_stat), .ls_stat(ls_stat),
  .verify(verify), .pseudo_random_check_pin(pseudo_random_check_pin),
  .slow_status_lane_select(slow_status_lane_select));

//--- test/csec_mgmt_station.sv
// Management station model issuing single register reads and writes
`timescale 1ns/1ps

module csec_mgmt_station (
  // Clock
  input wire logic clk,
  // Register bus
  output csec_pkg::csec_mgmt_req_t mgmt_req,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid
);
  import csec_pkg::*;
  initial mgmt_req = '0;
  // Stale address and data are inverted once released so nothing leans on them
  task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] wdata,
                        output logic [15:0] rdata, output logic ok);
    @(posedge clk);
    mgmt_req <= '{rd_stb: !wr, wr_stb: wr, addr: addr, wdata: wdata};
    @(posedge clk);
    mgmt_req <= '{rd_stb: 1'b0, wr_stb: 1'b0, addr: ~addr, wdata: ~wdata};
    #1;
    rdata = mgmt_rdata;
    ok = wr || mgmt_rvalid === 1'b1;
  endtask : access
endmodule : csec_mgmt_station

//--- test/tb_channel_status_error_counters.sv
// Self-checking testbench for the channel status and error counter bank
`timescale 1ns/1ps
`include "csec_regs.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, got, exp); end end

module tb_channel_status_error_counters;
  import csec_pkg::*;
  logic clk;
  logic rst = 1'b1;
  logic datapath_reset = 1'b0;
  logic pseudo_random_check_pin = 1'b0;
  csec_hs_stat_t hs = 11'h100;
  csec_ls_stat_t ls = '0;
  csec_verify_t vfy = '0;
  csec_mgmt_req_t mgmt_req;
  logic [15:0] mgmt_rdata;
  logic mgmt_rvalid;
  logic [1:0] lane_sel;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;

  csec_status_bank #(.CNT_W(16)) u_csec_status_bank (.clk(clk), .rst(rst),
    .datapath_reset(datapath_reset), .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid), .hs_stat(hs), .ls_stat(ls), .verify(vfy),
    .pseudo_random_check_pin(pseudo_random_check_pin), .slow_status_lane_select(lane_sel));
  csec_mgmt_station u_station (.clk(clk), .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      summarize();
    end
  end

  task automatic chk_rd(input logic [15:0] addr, input logic [15:0] mask, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    u_station.access(1'b0, addr, 16'h0000, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d & mask, exp)
  endtask : chk_rd
  task automatic wr(input logic [15:0] addr, input logic [15:0] data);
    logic [15:0] d;
    logic ok;
    u_station.access(1'b1, addr, data, d, ok);
  endtask : wr

  task automatic t_reset_values;
    chk_rd(`CSEC_OFS_HS_ERR, 16'hffff, `CSEC_ERR_RESET);
    chk_rd(`CSEC_OFS_HS_ERR, 16'hffff, 16'h0000);
    chk_rd(`CSEC_OFS_LS0_ERR, 16'hffff, `CSEC_ERR_RESET);
    chk_rd(`CSEC_OFS_LS0_ERR, 16'hffff, 16'h0000);
    chk_rd(`CSEC_OFS_LS_STATUS, 16'hffff, 16'h0000);
    chk_rd(`CSEC_OFS_LANE_CFG, 16'hffff, 16'h0000);
    wr(16'h0005, 16'hffff);
    chk_rd(16'h0005, 16'hffff, 16'h0000);
  endtask : t_reset_values

  task automatic t_live;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      hs.pat_aligned <= i[0];
      ls.pat_aligned <= i[0];
      hs.gain_locked <= i[0];
      hs.sync <= i[0];
      hs.slow_pll_locked <= i[0];
      hs.fast_pll_locked <= i[0];
      chk_rd(`CSEC_OFS_CHAN_STATUS, 16'hcc03, i[0] ? 16'hcc03 : 16'h0000);
    end
  endtask : t_live

  task automatic t_counts;
    @(posedge clk);
    hs.bad_codeword <= 1'b1;
    ls.bad_codeword <= 1'b1;
    repeat (3) @(posedge clk);
    hs.bad_codeword <= 1'b0;
    ls.bad_codeword <= 1'b0;
    chk_rd(`CSEC_OFS_HS_ERR, 16'hffff, 16'h0003);
    chk_rd(`CSEC_OFS_LS0_ERR, 16'hffff, 16'h0003);
    for (int p = 0; p < 8; p++) begin
      @(posedge clk);
      vfy <= '{hs_verify_en: 1'b1, hs_pattern: p[2:0], ls_verify_en: 1'b1, ls_pattern: p[2:0]};
      @(posedge clk);
      hs.pattern_err <= 1'b1;
      ls.pattern_err <= 1'b1;
      repeat (2) @(posedge clk);
      hs.pattern_err <= 1'b0;
      ls.pattern_err <= 1'b0;
      chk_rd(`CSEC_OFS_HS_ERR, 16'hffff, p >= 3 ? 16'h0002 : 16'h0000);
      chk_rd(`CSEC_OFS_LS0_ERR, 16'hffff, p >= 3 ? 16'h0002 : 16'h0000);
    end
    @(posedge clk);
    vfy <= '{hs_verify_en: 1'b0, hs_pattern: 3'h5, ls_verify_en: 1'b0, ls_pattern: 3'h0};
    pseudo_random_check_pin <= 1'b1;
    repeat (8) @(posedge clk);
    hs.pattern_err <= 1'b1;
    @(posedge clk);
    hs.pattern_err <= 1'b0;
    pseudo_random_check_pin <= 1'b0;
    chk_rd(`CSEC_OFS_HS_ERR, 16'hffff, 16'h0001);
    repeat (8) @(posedge clk);
  endtask : t_counts

  task automatic t_latch;
    chk_rd(`CSEC_OFS_CHAN_STATUS, 16'h0000, 16'h0000);
    @(posedge clk);
    hs <= hs ^ 11'h32c;
    @(posedge clk);
    hs <= hs ^ 11'h32c;
    chk_rd(`CSEC_OFS_CHAN_STATUS, 16'h3150, 16'h2150);
    chk_rd(`CSEC_OFS_CHAN_STATUS, 16'h3150, 16'h1000);
  endtask : t_latch

  task automatic t_lane;
    @(posedge clk);
    ls <= 5'h1e;
    @(posedge clk);
    ls <= 5'h00;
    @(posedge clk);
    ls.sync <= 1'b1;
    chk_rd(`CSEC_OFS_LS_STATUS, 16'h0508, 16'h0408);
    chk_rd(`CSEC_OFS_LS_STATUS, 16'h0508, 16'h0100);
    wr(`CSEC_OFS_LANE_CFG, 16'h1000);
    chk_rd(`CSEC_OFS_LANE_CFG, 16'hffff, 16'h1000);
    `CHK(lane_sel, 2'h1)
    chk_rd(`CSEC_OFS_LS_STATUS, 16'h0508, 16'h0000);
    wr(`CSEC_OFS_LANE_CFG, 16'h0000);
    @(posedge clk);
    datapath_reset <= 1'b1;
    @(posedge clk);
    datapath_reset <= 1'b0;
    chk_rd(`CSEC_OFS_HS_ERR, 16'hffff, `CSEC_ERR_RESET);
  endtask : t_lane

  task automatic summarize;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset_values();
    t_live();
    t_counts();
    t_latch();
    t_lane();
    summarize();
  end
endmodule : tb_channel_status_error_counters
